/* File: common/cpd_pkg.sv */
// Package for the character pattern display engine: map, fields, timing, carriers
package cpd_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [11:0] CPD_CTRL_OFS     = 12'h000;
  localparam logic [11:0] CPD_CURSOR_OFS   = 12'h004;
  localparam logic [11:0] CPD_STATUS_OFS   = 12'h008;
  localparam logic [11:0] CPD_PAT_BASE     = 12'h100;
  localparam logic [11:0] CPD_CHR_BASE     = 12'h200;
  localparam logic [11:0] CPD_MAP_END      = 12'h400;

  // Control register field positions
  localparam int CPD_CTRL_FONT10_BIT  = 0;
  localparam int CPD_CTRL_TWOLINE_BIT = 1;
  localparam int CPD_CTRL_DISPON_BIT  = 2;
  localparam int CPD_CTRL_CURSOR_BIT  = 3;
  localparam int CPD_CTRL_BLINK_BIT   = 4;
  localparam logic [4:0] CPD_CTRL_RESET = 5'h00;

  // Array sizes
  localparam int CPD_PAT_WORDS = 64;
  localparam int CPD_CHR_WORDS = 128;
  localparam int CPD_SEGS      = 40;
  localparam int CPD_COMS      = 16;
  localparam int CPD_DOTS      = 5;

  // Display geometry
  localparam logic [6:0] CPD_LINE2_BASE = 7'h40;
  localparam logic [3:0] CPD_ROW_CURSOR8  = 4'h7;
  localparam logic [3:0] CPD_ROW_CURSOR10 = 4'ha;
  localparam logic [3:0] CPD_DUTY_8  = 4'h7;
  localparam logic [3:0] CPD_DUTY_11 = 4'ha;
  localparam logic [3:0] CPD_DUTY_16 = 4'hf;

  // Timing: dot shift rate follows the internal oscillator rate
  localparam int CPD_CLK_FREQ_KHZ = 100000;
  localparam int CPD_OSC_FREQ_KHZ = 250;
  localparam int CPD_DOT_DIV      = CPD_CLK_FREQ_KHZ / CPD_OSC_FREQ_KHZ;
  localparam int CPD_BLINK_FRAMES = 32;

  localparam logic [1:0] CPD_HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } cpd_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } cpd_ahb_rsp_t;

  typedef struct packed {
    logic blink_en;
    logic cursor_en;
    logic disp_on;
    logic two_lines;
    logic font10;
  } cpd_ctrl_t;

endpackage

/* File: verilog/cpd_fixed_rom.sv */
// Fixed pattern ROM stand-in for codes outside the user pattern range
`timescale 1ns/10ps
module cpd_fixed_rom
  import cpd_pkg::*;
(
  // Lookup
  input  wire logic [7:0] code,
  input  wire logic [3:0] row,
  // Row dots, bit 4 leftmost
  output logic      [4:0] dots
);

  // Glyph contents are out of scope: every nonzero code shows a framed box, code 00 is blank
  always_comb begin
    dots = 5'h00;
    if (code != 8'h00) begin
      if (row == 4'h0 || row == 4'h6) begin
        dots = 5'h1f;
      end else if (row < 4'h6) begin
        dots = 5'h11;
      end
    end
  end

endmodule // cpd_fixed_rom

/* File: verilog/cpd_seg_shift.sv */
// Serial segment shift register with output latch
`timescale 1ns/10ps
module cpd_seg_shift
  import cpd_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  // Serial input
  input  wire logic                shift_en,
  input  wire logic                din,
  input  wire logic                last,
  // Latched segment drive, index 0 is the leftmost segment
  output logic [CPD_SEGS-1:0]      seg
);

  logic [CPD_SEGS-1:0] sr;
  logic [CPD_SEGS-1:0] next_sr;

  assign next_sr = {sr[CPD_SEGS-2:0], din};

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sr <= '0;
    end else if (shift_en) begin
      sr <= next_sr;
    end
  end

  // Latch once the head character has entered; the last dot shifted lands in segment 0
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      seg <= '0;
    end else if (shift_en && last) begin
      seg <= next_sr;
    end
  end

endmodule // cpd_seg_shift

/* File: verilog/cpd_display_engine.sv */
// Character pattern display engine: pattern RAMs, scan, cursor/blink, AHB-Lite registers
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
module cpd_display_engine
  import cpd_pkg::*;
#(
  parameter int unsigned DOT_DIV      = CPD_DOT_DIV,
  parameter int unsigned BLINK_FRAMES = CPD_BLINK_FRAMES
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  // AHB-Lite slave
  input  wire cpd_ahb_req_t        ahb_req,
  output cpd_ahb_rsp_t             ahb_rsp,
  // Panel drive
  output logic [CPD_COMS-1:0]      com,
  output logic [CPD_SEGS-1:0]      seg
);

  // Storage
  logic [7:0] user_pattern_ram [CPD_PAT_WORDS];
  logic [7:0] char_code_ram    [CPD_CHR_WORDS];
  cpd_ctrl_t  ctrl;
  logic [6:0] cursor_address_counter;

  // Bus state
  logic        ap_valid;
  logic        wr_pend;
  logic        rd_pend;
  logic [11:0] ap_addr;
  logic        ap_mapped;
  logic [31:0] hrdata;
  logic        ctrl_we;
  logic        cur_we;
  logic        pat_we;
  logic        chr_we;
  logic [31:0] status_word;

  // Scan state
  logic [15:0] div_cnt;
  logic        dot_en;
  logic [2:0]  dot_cnt;
  logic [2:0]  pos;
  logic [3:0]  row;
  logic [7:0]  frame_cnt;
  logic        blink_phase;
  logic        last_dot;
  logic        row_end;
  logic        frame_end;

  // Display path
  logic        font10_eff;
  logic [3:0]  duty_max;
  logic [3:0]  prow;
  logic        line2;
  logic [6:0]  char_addr;
  logic [7:0]  code;
  logic [5:0]  user_addr;
  logic [4:0]  user_row;
  logic [4:0]  rom_row;
  logic [4:0]  base_row;
  logic [4:0]  row_bits;
  logic        at_cursor;
  logic        cursor_row;
  logic        dot;

  function automatic logic in_window(input logic [11:0] a, input logic [11:0] base,
                                     input int words);
    return (a >= base) && (a < base + 12'(words * 4));
  endfunction

  // ---------------- AHB-Lite slave ----------------
  assign ap_valid = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];

  // Write strobes, one per storage target, all in the data phase
  assign ctrl_we = wr_pend && ap_mapped && (ap_addr == CPD_CTRL_OFS);
  assign cur_we  = wr_pend && ap_mapped && (ap_addr == CPD_CURSOR_OFS);
  assign pat_we  = wr_pend && ap_mapped && in_window(ap_addr, CPD_PAT_BASE, CPD_PAT_WORDS);
  assign chr_we  = wr_pend && ap_mapped && in_window(ap_addr, CPD_CHR_BASE, CPD_CHR_WORDS);
  assign status_word = {22'h0, frame_cnt[0], blink_phase, 1'b0, pos, row};

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ap_addr <= 12'h000;
      ap_mapped <= 1'b0;
    end else begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      if (ap_valid) begin
        wr_pend <= ahb_req.hwrite;
        rd_pend <= !ahb_req.hwrite;
        ap_addr <= ahb_req.haddr[11:0];
        ap_mapped <= (ahb_req.haddr[31:12] == 20'h00000) &&
                     (ahb_req.haddr[11:0] < CPD_MAP_END);
      end
    end
  end

  // Reads insert one wait state so the data come from a flop
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend) begin
      hrdata <= 32'h0000_0000;
      if (!ap_mapped) begin
        hrdata <= 32'h0000_0000;
      end else if (ap_addr == CPD_CTRL_OFS) begin
        hrdata <= {27'h0, ctrl};
      end else if (ap_addr == CPD_CURSOR_OFS) begin
        hrdata <= {25'h0, cursor_address_counter};
      end else if (ap_addr == CPD_STATUS_OFS) begin
        hrdata <= status_word;
      end else if (in_window(ap_addr, CPD_PAT_BASE, CPD_PAT_WORDS)) begin
        hrdata <= {24'h0, user_pattern_ram[ap_addr[7:2]]};
      end else if (in_window(ap_addr, CPD_CHR_BASE, CPD_CHR_WORDS)) begin
        hrdata <= {24'h0, char_code_ram[ap_addr[8:2]]};
      end
    end
  end

  assign ahb_rsp.hrdata    = hrdata;
  assign ahb_rsp.hreadyout = !rd_pend;
  assign ahb_rsp.hresp     = 1'b0;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CPD_CTRL_RESET;
      cursor_address_counter <= 7'h00;
    end else begin
      if (ctrl_we) begin
        ctrl.font10    <= ahb_req.hwdata[CPD_CTRL_FONT10_BIT];
        ctrl.two_lines <= ahb_req.hwdata[CPD_CTRL_TWOLINE_BIT];
        ctrl.disp_on   <= ahb_req.hwdata[CPD_CTRL_DISPON_BIT];
        ctrl.cursor_en <= ahb_req.hwdata[CPD_CTRL_CURSOR_BIT];
        ctrl.blink_en  <= ahb_req.hwdata[CPD_CTRL_BLINK_BIT];
      end
      if (cur_we) begin
        cursor_address_counter <= ahb_req.hwdata[6:0];
      end
    end
  end

  // Host writes go straight into the arrays; refresh reads use their own port
  always_ff @(posedge ref_clk) begin
    if (pat_we) begin
      user_pattern_ram[ap_addr[7:2]] <= ahb_req.hwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (chr_we) begin
      char_code_ram[ap_addr[8:2]] <= ahb_req.hwdata[7:0];
    end
  end

  // ---------------- Dot rate divider ----------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 16'h0000;
    end else if (div_cnt == 16'(DOT_DIV - 1)) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  assign dot_en = (div_cnt == 16'(DOT_DIV - 1));

  // ---------------- Scan counters ----------------
  assign font10_eff = ctrl.font10 && !ctrl.two_lines;

  // Last scanned row; two lines force the 5x8 font
  always_comb begin
    if (ctrl.two_lines) begin
      duty_max = CPD_DUTY_16;
    end else if (font10_eff) begin
      duty_max = CPD_DUTY_11;
    end else begin
      duty_max = CPD_DUTY_8;
    end
  end

  assign last_dot   = (pos == 3'h0) && (dot_cnt == 3'(CPD_DOTS - 1));
  assign row_end    = dot_en && last_dot;
  assign frame_end  = row_end && (row >= duty_max);

  // Transfer walks characters from the last position down to the head
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dot_cnt <= 3'h0;
      pos     <= 3'h7;
    end else if (dot_en) begin
      if (dot_cnt == 3'(CPD_DOTS - 1)) begin
        dot_cnt <= 3'h0;
        pos     <= pos - 3'h1;
      end else begin
        dot_cnt <= dot_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      row <= 4'h0;
    end else if (frame_end) begin
      row <= 4'h0;
    end else if (row_end) begin
      row <= row + 4'h1;
    end
  end

  // Blink phase toggles every BLINK_FRAMES frames
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      frame_cnt   <= 8'h00;
      blink_phase <= 1'b0;
    end else if (frame_end) begin
      if (frame_cnt == 8'(BLINK_FRAMES - 1)) begin
        frame_cnt   <= 8'h00;
        blink_phase <= !blink_phase;
      end else begin
        frame_cnt <= frame_cnt + 8'h01;
      end
    end
  end

  // Common drive updates together with the segment latch
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      com <= '0;
    end else if (row_end) begin
      com <= 16'h0001 << row;
    end
  end

  // ---------------- Refresh read path ----------------
  assign line2     = ctrl.two_lines && row[3];
  assign prow      = ctrl.two_lines ? {1'b0, row[2:0]} : row;
  assign char_addr = (line2 ? CPD_LINE2_BASE : 7'h00) + {4'h0, pos};
  assign code      = char_code_ram[char_addr];

  always_comb begin
    if (font10_eff) begin
      user_addr = {code[2:1], prow[3:0]};
    end else begin
      user_addr = {code[2:0], prow[2:0]};
    end
  end

  assign user_row = user_pattern_ram[user_addr][4:0];

  cpd_fixed_rom u_rom (
    .code (code),
    .row  (prow),
    .dots (rom_row)
  );

  assign base_row   = (code[7:4] == 4'h0) ? user_row : rom_row;
  assign at_cursor  = (char_addr == cursor_address_counter);
  assign cursor_row = font10_eff ? (prow == CPD_ROW_CURSOR10) : (prow == CPD_ROW_CURSOR8);

  always_comb begin
    // Cursor row data stays in the OR, so stray ones show anywhere
    row_bits = base_row | {CPD_DOTS{ctrl.cursor_en && at_cursor && cursor_row}};
    if (ctrl.blink_en && at_cursor && blink_phase) begin
      row_bits = 5'h1f;
    end
    if (!ctrl.disp_on) begin
      row_bits = 5'h00;
    end
  end

  // Bit 0 shifts first so bit 4 of the head character lands leftmost
  assign dot = row_bits[dot_cnt];

  cpd_seg_shift u_shift (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .shift_en (dot_en),
    .din      (dot),
    .last     (last_dot),
    .seg      (seg)
  );

endmodule // cpd_display_engine

/* File: tb/cpd_display_engine_checker.sv */
// Port assertions for the display engine
`timescale 1ns/10ps
module cpd_display_engine_checker
  import cpd_pkg::*;
#(
  parameter int unsigned DOT_DIV      = CPD_DOT_DIV,
  parameter int unsigned BLINK_FRAMES = CPD_BLINK_FRAMES
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  // Bus and panel
  input  wire cpd_ahb_req_t        ahb_req,
  input  wire cpd_ahb_rsp_t        ahb_rsp,
  input  wire logic [CPD_COMS-1:0] com,
  input  wire logic [CPD_SEGS-1:0] seg
);
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [CPD_COMS-1:0] com_q;
  logic [31:0]         cnt;
  logic                take;
  assign take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
  // Cycles since the last common change
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      com_q <= '0;
      cnt   <= '0;
    end else begin
      com_q <= com;
      cnt   <= (com != com_q) ? 32'h0 : cnt + 32'h1;
    end
  end
  property p_okay; ahb_rsp.hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_wr_fast; take && ahb_req.hwrite |=> ahb_rsp.hreadyout; endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  property p_rd_wait;
    take && !ahb_req.hwrite |=> !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_onehot; $onehot0(com); endproperty
  a_onehot: assert property (p_onehot) else $error("two commons selected");
  property p_order;
    (com != com_q) && (com_q != '0) |-> (com == (com_q << 1)) || (com == 16'h1);
  endproperty
  a_order: assert property (p_order) else $error("common order wrong");
  property p_period;
    (com != com_q) && (com_q != '0) && (com != '0) |-> cnt == 32'(40 * DOT_DIV - 1);
  endproperty
  a_period: assert property (p_period) else $error("row period wrong");
  property p_latch; $changed(seg) |-> $changed(com); endproperty
  a_latch: assert property (p_latch) else $error("segments moved mid row");
  property p_rst_idle; $rose(rstn) |-> com == '0 && seg == '0 && ahb_rsp.hreadyout; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
endmodule // cpd_display_engine_checker
bind cpd_display_engine cpd_display_engine_checker #(
  .DOT_DIV(DOT_DIV), .BLINK_FRAMES(BLINK_FRAMES)
) chk_u (
  .ref_clk(ref_clk), .rstn(rstn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .com(com), .seg(seg)
);

/* File: tb/cpd_panel_model.sv */
// Panel stand-in: keeps the segment row latched for each common
`timescale 1ns/10ps
module cpd_panel_model
  import cpd_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  // Electrodes
  input  wire logic [CPD_COMS-1:0] com,
  input  wire logic [CPD_SEGS-1:0] seg,
  // Captured rows and latch count
  output logic      [CPD_SEGS-1:0] row_img [CPD_COMS],
  output logic      [15:0]         latches
);
  logic [CPD_COMS-1:0] com_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      com_q   <= '0;
      latches <= '0;
    end else begin
      com_q <= com;
      if (com != com_q && com != '0) begin
        latches <= latches + 16'h1;
        for (int i = 0; i < CPD_COMS; i++) begin
          if (com[i]) begin
            row_img[i] <= seg;
          end
        end
      end
    end
  end
endmodule // cpd_panel_model

/* File: tb/tb_top.sv */
// Self-checking bench for the display engine
`timescale 1ns/10ps
module tb_top
  import cpd_pkg::*;
;
  typedef struct packed {
    logic [4:0]  c;
    logic [6:0]  cur;
    logic [15:0] m;
  } cpd_case_t;
  logic         ref_clk;
  logic         rstn;
  logic         sel;
  logic         wr;
  logic [1:0]   trans;
  logic [31:0]  addr;
  logic [31:0]  wdata;
  logic [31:0]  q;
  logic [15:0]  lat;
  logic [15:0]  cmask;
  logic [39:0]  pnl_img [16];
  logic [7:0]   pat [64];
  logic [7:0]   chr [128];
  cpd_ahb_req_t ahb_req;
  cpd_ahb_rsp_t ahb_rsp;
  logic [15:0]  com;
  logic [39:0]  seg;
  int           bad_count;
  int           checks_done;
  int           on;
  int           off;
  cpd_case_t    cases [6] = '{{5'h04, 7'h03, 16'h00ff}, {5'h0c, 7'h02, 16'h00ff},
    {5'h05, 7'h00, 16'h07ff}, {5'h0d, 7'h05, 16'h07ff}, {5'h0e, 7'h41, 16'hffff},
    {5'h08, 7'h01, 16'h00ff}};
  assign ahb_req = {sel, addr, trans, wr, 3'h2, wdata, ahb_rsp.hreadyout};
  cpd_display_engine #(.DOT_DIV(2), .BLINK_FRAMES(1)) dut_u (.ref_clk(ref_clk), .rstn(rstn),
    .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .com(com), .seg(seg));
  cpd_panel_model pnl_u (.ref_clk(ref_clk), .rstn(rstn), .com(com), .seg(seg),
    .row_img(pnl_img), .latches(lat));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Waits for an edge that sees hready high; read data taken there
  task automatic await;
    logic r;
    do begin
      @(negedge ref_clk);
      r = ahb_rsp.hreadyout;
      q = ahb_rsp.hrdata;
      @(posedge ref_clk);
    end while (r !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    sel <= 1'b1;
    trans <= CPD_HTRANS_NONSEQ;
    wr <= w;
    addr <= {20'h0, a};
    await();
    sel <= 1'b0;
    trans <= 2'h0;
    wdata <= d;
    await();
  endtask
  task automatic rows(input int n);
    int t;
    logic dn;
    t = lat + n;
    cmask = '0;
    do begin
      @(negedge ref_clk);
      cmask |= com;
      dn = (lat >= t);
      @(posedge ref_clk);
    end while (!dn);
  endtask
  function automatic logic [39:0] img(input logic [4:0] c, input logic [6:0] cur,
                                      input int r, input logic blk);
    logic [39:0] s;
    logic [6:0]  a;
    logic [7:0]  k;
    logic [4:0]  d;
    s = '0;
    for (int p = 0; p < 8; p++) begin
      a = 7'(p) + ((c[1] && r > 7) ? 7'h40 : 7'h00);
      k = chr[a];
      d = pat[c[0] ? {k[2:1], 4'(r)} : {k[2:0], 3'(r)}][4:0];
      if (c[3] && a == cur && (c[0] ? r == 10 : r % 8 == 7)) d = 5'h1f;
      if (blk && c[4] && a == cur) d = 5'h1f;
      for (int b = 0; b < 5; b++) s[5 * p + 4 - b] = d[b] & c[2];
    end
    return s;
  endfunction
  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end
  initial begin
    rstn = 1'b0;
    sel = 1'b0;
    wr = 1'b0;
    trans = 2'h0;
    addr = '0;
    wdata = '0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(0, CPD_CTRL_OFS, 0);
    chk("ctrl reset", 40'(q), 40'h0);
    // Cursor rows get set bits on purpose: they must light with no cursor
    for (int i = 0; i < 64; i++) begin
      pat[i] = 8'(i * 7);
      bus(1, CPD_PAT_BASE + 12'(4 * i), 32'(pat[i]));
    end
    for (int a = 0; a < 128; a++) chr[a] = 8'((a * 9 + (a >> 6) * 5) & 15);
    for (int k = 0; k < 16; k++) bus(1, CPD_CHR_BASE + 12'(4 * ((k & 7) + (k >> 3) * 64)),
                                     32'(chr[(k & 7) + (k >> 3) * 64]));
    bus(0, CPD_PAT_BASE + 12'h024, 0);
    chk("pattern readback", 40'(q), 40'(pat[9]));
    bus(1, 12'h0fc, 32'hff);
    bus(0, 12'h0fc, 0);
    chk("unmapped", 40'(q), 40'h0);
    foreach (cases[i]) begin
      bus(1, CPD_CTRL_OFS, 32'(cases[i].c));
      bus(1, CPD_CURSOR_OFS, 32'(cases[i].cur));
      rows(16);
      rows(16);
      chk("commons", 40'(cmask), 40'(cases[i].m));
      for (int r = 0; r < 16; r++) if (cases[i].m[r])
        chk("row image", pnl_img[r], img(cases[i].c, cases[i].cur, r, 1'b0));
    end
    bus(1, CPD_CTRL_OFS, 32'h14);
    bus(1, CPD_CURSOR_OFS, 32'h01);
    rows(16);
    for (int k = 0; k < 4; k++) begin
      rows(8);
      on += int'(pnl_img[0] === img(5'h14, 7'h01, 0, 1'b1));
      off += int'(pnl_img[0] === img(5'h14, 7'h01, 0, 1'b0));
    end
    chk("blink lit", 40'(on), 40'h2);
    chk("blink plain", 40'(off), 40'h2);
    // Cursor register reads back what was written; status spare bits read zero
    bus(0, CPD_CURSOR_OFS, 0);
    chk("cursor readback", 40'(q), 40'h01);
    bus(0, CPD_STATUS_OFS, 0);
    chk("status spare bits", 40'(q & 32'hffff_fc80), 40'h0);
    // Codes with upper bits set leave pattern RAM for the fixed box glyph
    bus(1, CPD_CTRL_OFS, 32'h04);
    bus(1, CPD_CHR_BASE, 32'h41);
    rows(16);
    chk("fixed glyph top", 40'(pnl_img[0][4:0]), 40'h1f);
    chk("fixed glyph side", 40'(pnl_img[1][4:0]), 40'h11);
    rstn <= 1'b0;
    @(negedge ref_clk);
    chk("reset commons", 40'(com), 40'h0);
    chk("reset segments", seg, 40'h0);
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(0, CPD_CTRL_OFS, 0);
    chk("ctrl rereset", 40'(q), 40'h0);
    stop_test();
  end
endmodule // tb_top
